// ### verilog/bridge_pkg.sv
// Shared constants, field layouts and state encodings of the read-path and write-error bridge
package bridge_pkg;
	// ------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam int IDX_W = 4;
	localparam int SUB_BITS = 8;
	localparam logic [CNT_W-1:0] BURST_WORDS = 5'h08;
	localparam logic [2:0] BURST_LAST_BEAT = 3'h7;
	localparam logic [31:0] SINGLE_SPAN_BYTES = 32'h0000_0020;
	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] WRITE_ERROR_STATUS_OFFSET = 8'h04;
	localparam logic [7:0] TRIGGER_LEVELS_OFFSET = 8'h08;
	localparam logic [7:0] LOCAL_BASE_OFFSET = 8'h0c;
	localparam logic [7:0] LOCAL_LIMIT_OFFSET = 8'h10;
	localparam logic [7:0] READ_STATE_OFFSET = 8'h14;
	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0300;
	localparam logic [31:0] TRIGGER_LEVELS_RESET = 32'h0000_0804;
	localparam logic [31:0] LOCAL_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] LOCAL_LIMIT_RESET = 32'hffff_fffc;
	localparam int INHIBIT_BIT = 0;
	localparam int RETRY_LIMIT_LSB = 8;
	localparam int FIRST_LEVEL_LSB = 0;
	localparam int PREFETCH_LEVEL_LSB = 8;
	localparam int STATUS_W = 9;
	localparam int ST_SERR = 0;
	localparam int ST_MASTER_ABORT = 1;
	localparam int ST_RETRY = 2;
	localparam int ST_BURST_RETRY = 3;
	localparam int ST_RETRY_DISCONNECT = 4;
	localparam int ST_PERR = 5;
	localparam int ST_RETRY_TIMEOUT = 6;
	localparam int ST_TARGET_ABORT = 7;
	localparam int ST_READ_ERROR = 8;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_MEM_READ = 4'h6,
		CMD_MEM_READ_MULTIPLE = 4'hc,
		CMD_MEM_READ_LINE = 4'he
	} pci_cmd_t;
	typedef enum logic [2:0] {
		TERM_COMPLETE = 3'h0,
		TERM_SERR = 3'h1,
		TERM_MASTER_ABORT = 3'h2,
		TERM_RETRY = 3'h3,
		TERM_DISCONNECT = 3'h4,
		TERM_PERR = 3'h5,
		TERM_LATENCY_TIMEOUT = 3'h6,
		TERM_TARGET_ABORT = 3'h7
	} write_term_t;
	typedef enum logic [2:0] {
		RD_IDLE = 3'h0,
		RD_FETCH = 3'h1,
		RD_STREAM = 3'h2,
		RD_TERMINATE = 3'h3,
		RD_DRAIN = 3'h4
	} read_state_t;
endpackage : bridge_pkg

// ### verilog/read_fifo.sv
// Flip-flop prefetch FIFO carrying local read data toward the PCI side
`timescale 1ns/10ps
module read_fifo
	import bridge_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [bridge_pkg::DATA_W-1:0] push_data,
	input wire logic pop,
	input wire logic flush,
	output logic [bridge_pkg::DATA_W-1:0] head,
	output logic [bridge_pkg::CNT_W-1:0] count
);
	logic [DATA_W-1:0] store [FIFO_DEPTH];
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;
	logic do_push;
	logic do_pop;

	// Full and empty guards keep pointers honest
	assign do_push = push && (count != CNT_W'(FIFO_DEPTH));
	assign do_pop = pop && (count != '0);
	assign head = store[rd_idx];

	// Storage, written by index
	always_ff @(posedge clk)
	begin
		if (do_push)
			store[wr_idx] <= push_data;
	end

	// Pointers and occupancy; flush drops everything at once
	always_ff @(posedge clk)
	begin
		if (!rst_b || flush)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
		end
		else
		begin
			if (do_push)
				wr_idx <= wr_idx + 1'b1;
			if (do_pop)
				rd_idx <= rd_idx + 1'b1;
			if (do_push && !do_pop)
				count <= count + 1'b1;
			else if (do_pop && !do_push)
				count <= count - 1'b1;
		end
	end
endmodule : read_fifo

// ### verilog/pci_bridge_core.sv
// Bridge top: posted-write error handling and PCI-initiated read path with prefetch
//
// Contract
// - Error on a local burst in progress gives error and transfer acknowledge together.
// - SERR raises SERR status; burst writes also flush the write FIFO.
// - Master abort raises its status and flushes, single or burst.
// - Retries reissue up to limit; final retry raises retry status, burst flushes.
// - Burst disconnect retried up to limit; final one raises disconnect status, flush.
// - Data PERR raises PERR status; burst also flushes the FIFO.
// - Burst latency timeout retried to limit; final raises timeout status, flush.
// - Target abort raises its status and flushes the write FIFO.
// - With inhibit enabled, error status blocks local writes until cleared.
// - Only memory read, read multiple and read line are answered.
// - Local retry before first data becomes a PCI retry.
// - Only one PCI-initiated read is serviced at a time.
// - Memory read substitutes high bits, low bits from lowest byte lane.
// - Read multiple and read line use a word-aligned local address.
// - Burst reads assert all byte enables, ignoring PCI byte enables.
// - Memory read is one single local read, then disconnect with data.
// - Eight-word bursts fill FIFO; near the limit switch to singles.
// - Initiator termination discards unread prefetched data.
// - FIFO data reaches the PCI side within two PCI clocks.
// - FIFO empty after first data phase gives disconnect without data.
// - Read multiple holds first data until the first-transfer trigger level.
// - At the prefetch trigger level further local reads are started.
`timescale 1ns/10ps
module pci_bridge_core
	import bridge_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Posted write, local side
	input wire logic local_write_start,
	input wire logic local_sequential_address,
	input wire logic local_write_busy,
	output logic bridge_error_acknowledge,
	output logic bridge_transfer_acknowledge,
	output logic local_write_inhibit,
	output logic local_to_pci_fifo_flush,
	// Posted write, PCI core side
	input wire logic pci_write_done_toggle,
	input wire logic [2:0] pci_write_term,
	output logic pci_write_reissue,
	// PCI target read side
	input wire logic pci_clk,
	input wire logic pci_read_cmd_valid,
	input wire logic [3:0] pci_read_cmd,
	input wire logic [31:0] pci_read_addr,
	input wire logic [3:0] pci_read_be_b,
	input wire logic pci_data_request,
	input wire logic pci_read_end,
	output logic [31:0] pci_read_data,
	output logic pci_read_data_valid,
	output logic pci_disconnect_with_data,
	output logic pci_disconnect_without_data,
	output logic pci_retry,
	// Local read master
	output logic local_read_request,
	output logic [31:0] local_read_addr,
	output logic [3:0] local_read_be,
	output logic local_read_burst,
	input wire logic local_read_ack,
	input wire logic [31:0] local_read_data,
	input wire logic local_read_retry,
	input wire logic local_read_error
);
	// ------------------------------------------------------------
	// Synchronisers for PCI-side pins
	// ------------------------------------------------------------
	logic [47:0] pin_meta;
	logic [47:0] pin_sync;
	logic pclk_d;
	logic wr_toggle_d;
	logic end_d;

	// Two flops on every pin from the PCI domain
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= {pci_clk, pci_read_cmd_valid, pci_read_cmd, pci_read_addr,
				pci_read_be_b, pci_data_request, pci_read_end, pci_write_done_toggle,
				pci_write_term};
			pin_sync <= pin_meta;
		end
	end

	logic s_pclk;
	logic s_cmd_valid;
	logic [3:0] s_cmd;
	logic [31:0] s_addr;
	logic [3:0] s_be_b;
	logic s_data_req;
	logic s_end;
	logic s_wr_toggle;
	logic [2:0] s_term;
	logic pci_edge;
	logic write_event;
	assign {s_pclk, s_cmd_valid, s_cmd, s_addr, s_be_b, s_data_req, s_end, s_wr_toggle,
		s_term} = pin_sync;
	assign pci_edge = s_pclk && !pclk_d;
	assign write_event = s_wr_toggle ^ wr_toggle_d;

	// Edge detectors look only at synchronised copies
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pclk_d <= 1'b0;
			wr_toggle_d <= 1'b0;
			end_d <= 1'b0;
		end
		else
		begin
			pclk_d <= s_pclk;
			wr_toggle_d <= s_wr_toggle;
			end_d <= s_end;
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0] control;
	logic [31:0] trigger_levels;
	logic [31:0] local_base;
	logic [31:0] local_limit;
	logic [STATUS_W-1:0] write_error_status;
	logic [STATUS_W-1:0] status_set;
	logic [STATUS_W-1:0] status_clear;
	logic apb_access;
	logic apb_write;
	logic mapped;
	logic [31:0] read_mux;
	read_state_t rd_state;
	logic [CNT_W-1:0] fifo_count;

	assign apb_access = psel && penable && !pready;
	assign apb_write = psel && penable && pready && pwrite && mapped; // Lands at the pready edge
	assign status_clear = (apb_write && paddr[7:0] == WRITE_ERROR_STATUS_OFFSET) ?
		pwdata[STATUS_W-1:0] : '0;

	// Address decode; unmapped or high addresses answer with an error
	always_comb
	begin
		mapped = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'h0);
		read_mux = 32'h0000_0000;
		case (paddr[7:0])
			CONTROL_OFFSET: read_mux = control;
			WRITE_ERROR_STATUS_OFFSET: read_mux = {{(32-STATUS_W){1'b0}}, write_error_status};
			TRIGGER_LEVELS_OFFSET: read_mux = trigger_levels;
			LOCAL_BASE_OFFSET: read_mux = local_base;
			LOCAL_LIMIT_OFFSET: read_mux = local_limit;
			READ_STATE_OFFSET: read_mux = {21'h00_0000, fifo_count, 3'h0, rd_state};
			default: mapped = 1'b0;
		endcase
	end

	// One wait state so the answer leaves from flops
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= apb_access;
			pslverr <= apb_access && !mapped;
			prdata <= (apb_access && !pwrite && mapped) ? read_mux : 32'h0000_0000;
		end
	end

	// Writable configuration
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			control <= CONTROL_RESET;
			trigger_levels <= TRIGGER_LEVELS_RESET;
			local_base <= LOCAL_BASE_RESET;
			local_limit <= LOCAL_LIMIT_RESET;
		end
		else if (apb_write)
		begin
			case (paddr[7:0])
				CONTROL_OFFSET: control <= {20'h0_0000, pwdata[11:8], 7'h00, pwdata[0]};
				TRIGGER_LEVELS_OFFSET: trigger_levels <= {19'h0_0000, pwdata[12:8], 3'h0,
					pwdata[4:0]};
				LOCAL_BASE_OFFSET: local_base <= {pwdata[31:32-SUB_BITS], {(32-SUB_BITS){1'b0}}};
				LOCAL_LIMIT_OFFSET: local_limit <= {pwdata[31:2], 2'h0};
				default: control <= control;
			endcase
		end
	end

	// Sticky error bits, write one to clear; a new event beats the clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			write_error_status <= '0;
		else
			write_error_status <= (write_error_status & ~status_clear) | status_set;
	end

	// ------------------------------------------------------------
	// Posted write terminations
	// ------------------------------------------------------------
	logic write_is_burst;
	logic retrying;
	logic [3:0] retry_count;
	logic retry_left;
	logic [STATUS_W-1:0] write_set;
	logic err_term;
	logic do_flush;
	logic do_reissue;
	logic read_error_set;

	assign retry_left = retry_count < control[RETRY_LIMIT_LSB +: 4];
	assign status_set = write_set | ({{(STATUS_W-1){1'b0}}, read_error_set} << ST_READ_ERROR);

	// Classify each finished PCI write attempt
	always_comb
	begin
		write_set = '0;
		do_flush = 1'b0;
		do_reissue = 1'b0;
		err_term = 1'b0;
		if (write_event)
		begin
			case (write_term_t'(s_term))
				TERM_SERR:
				begin
					write_set[ST_SERR] = 1'b1;
					do_flush = write_is_burst;
					err_term = 1'b1;
				end
				TERM_MASTER_ABORT:
				begin
					write_set[ST_MASTER_ABORT] = 1'b1;
					do_flush = 1'b1;
					err_term = 1'b1;
				end
				TERM_RETRY:
				begin
					do_reissue = retry_left;
					write_set[ST_RETRY] = !retry_left && !write_is_burst;
					write_set[ST_BURST_RETRY] = !retry_left && write_is_burst;
					do_flush = !retry_left && write_is_burst;
				end
				TERM_DISCONNECT:
				begin
					// A single write that disconnects has completed
					do_reissue = retry_left && write_is_burst;
					write_set[ST_RETRY_DISCONNECT] = !retry_left && write_is_burst;
					do_flush = !retry_left && write_is_burst;
				end
				TERM_PERR:
				begin
					write_set[ST_PERR] = 1'b1;
					do_flush = write_is_burst;
					err_term = 1'b1;
				end
				TERM_LATENCY_TIMEOUT:
				begin
					do_reissue = retry_left && write_is_burst;
					write_set[ST_RETRY_TIMEOUT] = !retry_left && write_is_burst;
					do_flush = !retry_left && write_is_burst;
				end
				TERM_TARGET_ABORT:
				begin
					write_set[ST_TARGET_ABORT] = 1'b1;
					do_flush = 1'b1;
					err_term = 1'b1;
				end
				default: write_set = '0;
			endcase
		end
	end

	// Burst flag and retry count follow each new posted write
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			write_is_burst <= 1'b0;
			retry_count <= 4'h0;
			retrying <= 1'b0;
		end
		else if (local_write_start)
		begin
			write_is_burst <= local_sequential_address;
			retry_count <= 4'h0;
			retrying <= 1'b0;
		end
		else if (write_event)
		begin
			retry_count <= retry_count + {3'h0, do_reissue};
			retrying <= do_reissue;
		end
	end

	// Write-side outputs, all registered
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			bridge_error_acknowledge <= 1'b0;
			bridge_transfer_acknowledge <= 1'b0;
			local_to_pci_fifo_flush <= 1'b0;
			pci_write_reissue <= 1'b0;
			local_write_inhibit <= 1'b0;
		end
		else
		begin
			bridge_error_acknowledge <= err_term && write_is_burst && local_write_busy;
			bridge_transfer_acknowledge <= err_term && write_is_burst && local_write_busy;
			local_to_pci_fifo_flush <= do_flush;
			pci_write_reissue <= do_reissue;
			// Retries in flight also hold off new writes
			local_write_inhibit <= retrying || do_reissue ||
				(control[INHIBIT_BIT] && (|write_error_status[ST_TARGET_ABORT:0]));
		end
	end

	// ------------------------------------------------------------
	// PCI-initiated reads
	// ------------------------------------------------------------
	logic is_single;
	logic [31:0] next_addr;
	logic lm_busy;
	logic [2:0] beat;
	logic first_done;
	logic fetched;
	logic fetch_stop;
	logic issue;
	logic near_limit;
	logic push;
	logic pop;
	logic flush_rd;
	logic read_ended;
	logic cmd_ok;
	logic first_ready;
	logic [31:0] fifo_head;
	logic [4:0] first_level;
	logic [4:0] prefetch_level;

	assign first_level = trigger_levels[FIRST_LEVEL_LSB +: 5];
	assign prefetch_level = trigger_levels[PREFETCH_LEVEL_LSB +: 5];
	assign cmd_ok = (s_cmd == CMD_MEM_READ) || (s_cmd == CMD_MEM_READ_MULTIPLE) ||
		(s_cmd == CMD_MEM_READ_LINE);
	assign read_ended = s_end && !end_d;
	assign near_limit = (local_limit - next_addr) < SINGLE_SPAN_BYTES;
	// Data arriving after the initiator has gone is dropped
	assign push = local_read_ack && lm_busy && (rd_state == RD_FETCH || rd_state == RD_STREAM);
	assign pop = pci_edge && s_data_req && pci_read_data_valid && rd_state == RD_STREAM;
	assign flush_rd = read_ended || rd_state == RD_IDLE;
	assign first_ready = is_single ? (fifo_count != '0) :
		((fifo_count >= first_level && fifo_count != '0) ||
		(fetch_stop && !lm_busy && fifo_count != '0));
	// Start reads while room for a whole burst remains and occupancy is at or below the trigger level
	assign issue = !lm_busy && !fetch_stop && (rd_state == RD_FETCH || rd_state == RD_STREAM) &&
		(is_single ? !fetched : (fifo_count <= prefetch_level &&
		fifo_count <= CNT_W'(FIFO_DEPTH) - BURST_WORDS));

	read_fifo u_read_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.push(push),
		.push_data(local_read_data),
		.pop(pop),
		.flush(flush_rd),
		.head(fifo_head),
		.count(fifo_count)
	);

	// Read sequencer; a second command arriving before this one has drained is ignored
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rd_state <= RD_IDLE;
			is_single <= 1'b0;
			first_done <= 1'b0;
			read_error_set <= 1'b0;
		end
		else
		begin
			read_error_set <= 1'b0;
			case (rd_state)
				RD_IDLE:
					if (pci_edge && s_cmd_valid && cmd_ok)
					begin
						rd_state <= RD_FETCH;
						is_single <= (s_cmd == CMD_MEM_READ);
						first_done <= 1'b0;
					end
				RD_FETCH, RD_STREAM:
				begin
					if (read_ended)
						rd_state <= lm_busy ? RD_DRAIN : RD_IDLE;
					else if (lm_busy && local_read_error)
					begin
						read_error_set <= 1'b1;
						rd_state <= RD_TERMINATE;
					end
					else if (lm_busy && local_read_retry && !first_done && fifo_count == '0)
						rd_state <= RD_TERMINATE;
					else if (rd_state == RD_FETCH && first_ready)
					begin
						rd_state <= RD_STREAM;
						first_done <= 1'b1;
					end
				end
				RD_TERMINATE:
					if (read_ended)
						rd_state <= lm_busy ? RD_DRAIN : RD_IDLE;
				RD_DRAIN:
					if (!lm_busy)
						rd_state <= RD_IDLE;
				default: rd_state <= RD_IDLE;
			endcase
		end
	end

	// Local read master: single or eight-beat burst
	always_ff @(posedge clk)
	begin
		if (!rst_b || rd_state == RD_IDLE)
		begin
			lm_busy <= 1'b0;
			beat <= 3'h0;
			fetched <= 1'b0;
			fetch_stop <= 1'b0;
			next_addr <= 32'h0000_0000;
			local_read_request <= 1'b0;
			local_read_addr <= 32'h0000_0000;
			local_read_be <= 4'h0;
			local_read_burst <= 1'b0;
			if (rst_b && pci_edge && s_cmd_valid && cmd_ok)
				next_addr <= {local_base[31:32-SUB_BITS], s_addr[31-SUB_BITS:2], 2'h0};
		end
		else if (issue)
		begin
			lm_busy <= 1'b1;
			beat <= 3'h0;
			fetched <= 1'b1;
			local_read_request <= 1'b1;
			local_read_burst <= !is_single && !near_limit;
			if (is_single)
			begin
				local_read_be <= ~s_be_b;
				local_read_addr <= {next_addr[31:2], !s_be_b[0] ? 2'h0 : !s_be_b[1] ? 2'h1 :
					!s_be_b[2] ? 2'h2 : 2'h3};
			end
			else
			begin
				local_read_be <= 4'hf;
				local_read_addr <= next_addr;
			end
		end
		else if (lm_busy && (local_read_retry || local_read_error))
		begin
			// After first data a retry simply reissues from the same address
			lm_busy <= 1'b0;
			local_read_request <= 1'b0;
			fetch_stop <= local_read_error;
		end
		else if (lm_busy && local_read_ack)
		begin
			beat <= beat + 3'h1;
			next_addr <= next_addr + 32'h0000_0004;
			fetch_stop <= (next_addr + 32'h0000_0004) > local_limit;
			if (!local_read_burst || beat == BURST_LAST_BEAT)
			begin
				lm_busy <= 1'b0;
				local_read_request <= 1'b0;
				local_read_burst <= 1'b0;
			end
		end
	end

	// PCI-side answer, refreshed every cycle, well inside two PCI clocks
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pci_read_data <= 32'h0000_0000;
			pci_read_data_valid <= 1'b0;
			pci_disconnect_with_data <= 1'b0;
			pci_disconnect_without_data <= 1'b0;
			pci_retry <= 1'b0;
		end
		else
		begin
			pci_read_data <= fifo_head;
			pci_read_data_valid <= rd_state == RD_STREAM && fifo_count != '0 && !pop;
			// Last buffered word goes out as disconnect with data
			pci_disconnect_with_data <= rd_state == RD_STREAM &&
				(is_single || fifo_count == 5'h01);
			pci_disconnect_without_data <= rd_state == RD_TERMINATE ||
				(rd_state == RD_STREAM && fifo_count == '0);
			pci_retry <= rd_state == RD_TERMINATE && !first_done;
		end
	end
endmodule : pci_bridge_core

// ### testbench/bridge_asserts.sv
// Port-level checks on the bridge top
`timescale 1ns/10ps
module bridge_asserts
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bridge_error_acknowledge,
	input wire logic bridge_transfer_acknowledge,
	input wire logic local_read_request,
	input wire logic [31:0] local_read_addr,
	input wire logic [3:0] local_read_be,
	input wire logic local_read_burst,
	input wire logic local_read_ack,
	input wire logic local_read_retry,
	input wire logic local_read_error,
	input wire logic pci_read_end,
	input wire logic pci_read_data_valid,
	input wire logic pci_disconnect_with_data,
	input wire logic pci_disconnect_without_data,
	input wire logic pci_retry
);
	// --------
	// Properties
	// --------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_ack_pair;
		bridge_error_acknowledge |-> bridge_transfer_acknowledge;
	endproperty
	a_ack_pair: assert property (p_ack_pair) else $error("lone error ack");
	property p_ack_pulse;
		bridge_transfer_acknowledge |=> !bridge_transfer_acknowledge;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_burst_be;
		local_read_request && local_read_burst |-> local_read_be == 4'hf;
	endproperty
	a_burst_be: assert property (p_burst_be) else $error("burst lanes");
	property p_burst_align;
		local_read_request && local_read_burst |-> local_read_addr[1:0] == 2'h0;
	endproperty
	a_burst_align: assert property (p_burst_align) else $error("burst align");
	property p_retry_nodata;
		pci_retry |-> !pci_read_data_valid && pci_disconnect_without_data;
	endproperty
	a_retry_nodata: assert property (p_retry_nodata) else $error("retry with data");
	property p_disc_valid;
		$rose(pci_disconnect_with_data) |-> pci_read_data_valid;
	endproperty
	a_disc_valid: assert property (p_disc_valid) else $error("disconnect no data");
	property p_end_flush;
		$rose(pci_read_end) |-> ##[1:6] !pci_read_data_valid;
	endproperty
	a_end_flush: assert property (p_end_flush) else $error("data after end");
	// Address must not move while a local read waits
	property p_req_hold;
		local_read_request && !local_read_ack && !local_read_retry && !local_read_error
			|=> local_read_request && $stable(local_read_addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request moved");
	c_err: cover property (bridge_error_acknowledge);
	c_burst: cover property (local_read_burst && local_read_ack);
	c_disc: cover property ($rose(pci_disconnect_with_data));
endmodule : bridge_asserts
bind pci_bridge_core bridge_asserts chk (.*);

// ### testbench/local_slave_model.sv
// Behavioural local slave answering the bridge's reads
`timescale 1ns/10ps
module local_slave_model
(
	input wire logic clk,
	input wire logic req,
	input wire logic [31:0] addr,
	input wire logic burst,
	input wire logic slow,
	input wire logic do_retry,
	output logic ack,
	output logic [31:0] data,
	output logic retry
);
	int waited = 0, beat = 0, cool = 0;
	initial
	begin
		ack = 1'h0;
		retry = 1'h0;
		data = 32'h0;
	end
	// --------
	// Responder
	// --------
	// Idle data toggles so a stale word never looks valid
	always @(posedge clk)
	begin
		ack <= 1'h0;
		retry <= 1'h0;
		data <= ~data;
		if (cool > 0)
			cool <= cool - 1;
		else if (req && waited < (slow ? 30 : 0))
			waited <= waited + 1;
		else if (req && do_retry)
		begin
			retry <= 1'h1;
			cool <= 2;
			waited <= 0;
		end
		else if (req)
		begin
			ack <= 1'h1;
			data <= addr + 32'(4 * beat);
			beat <= (burst && beat < 7) ? beat + 1 : 0;
			if (!burst || beat == 7)
			begin
				cool <= 2;
				waited <= 0;
			end
		end
	end
endmodule : local_slave_model

// ### testbench/tb.sv
// Self-checking bench: write errors and PCI read path
`timescale 1ns/10ps
module tb;
	import bridge_pkg::*;
	logic clk = 0, pci_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic local_write_start = 0, local_sequential_address = 0, local_write_busy = 0;
	logic pci_write_done_toggle = 0, pci_read_cmd_valid = 0, pci_data_request = 0;
	logic pci_read_end = 0, local_read_error = 0, slow = 0, do_retry = 0;
	logic [2:0] pci_write_term = 0;
	logic [3:0] pci_read_cmd = 0, pci_read_be_b = 0, local_read_be, s;
	logic [31:0] paddr = 0, pwdata = 0, pci_read_addr = 0, r, prdata, pci_read_data;
	logic [31:0] local_read_addr, local_read_data;
	logic pready, pslverr, bridge_error_acknowledge, bridge_transfer_acknowledge;
	logic local_write_inhibit, local_to_pci_fifo_flush, pci_write_reissue, pci_retry;
	logic pci_read_data_valid, pci_disconnect_with_data, pci_disconnect_without_data;
	logic local_read_request, local_read_burst, local_read_ack, local_read_retry;
	int err_total = 0, checks = 0;
	pci_bridge_core uut (.*);
	local_slave_model slave (.clk, .req(local_read_request), .addr(local_read_addr),
		.burst(local_read_burst), .slow, .do_retry, .ack(local_read_ack),
		.data(local_read_data), .retry(local_read_retry));
	// Clocks: link clock on its own phase
	always #2 clk = ~clk;
	always #16 pci_clk = ~pci_clk;
	// --------
	// Helpers
	// --------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// One posted write ended by code c; collect pulses and status
	task automatic wr(input logic [2:0] c, input logic b, st, input logic [3:0] es,
		input logic [8:0] ss);
		@(posedge clk);
		local_write_start <= st;
		local_sequential_address <= b;
		local_write_busy <= b;
		pci_write_term <= c;
		@(posedge clk);
		local_write_start <= 1'h0;
		pci_write_done_toggle <= ~pci_write_done_toggle;
		s = 4'h0;
		repeat (10) @(posedge clk) s |= {local_to_pci_fifo_flush, bridge_error_acknowledge,
			bridge_transfer_acknowledge, pci_write_reissue};
		cmp(s, es);
		apb(0, WRITE_ERROR_STATUS_OFFSET, 0);
		cmp(r[8:0], ss);
		cmp(local_write_inhibit, ss != 0 || es[0]);
		apb(1, WRITE_ERROR_STATUS_OFFSET, 32'h1ff);
		repeat (2) @(posedge clk);
		cmp(local_write_inhibit, es[0]);
	endtask : wr
	task automatic rd_cmd(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be);
		@(posedge clk);
		pci_read_end <= 1'h0;
		pci_read_cmd <= c;
		pci_read_addr <= a;
		pci_read_be_b <= be;
		pci_read_cmd_valid <= 1'h1;
		repeat (12) @(posedge clk);
		pci_read_cmd_valid <= 1'h0;
	endtask : rd_cmd
	task automatic take(input logic [31:0] x);
		do @(posedge clk); while (pci_read_data_valid !== 1'h1);
		cmp(pci_read_data, x);
		pci_data_request <= 1'h1;
		do @(posedge clk); while (pci_read_data_valid === 1'h1);
		pci_data_request <= 1'h0;
	endtask : take
	task automatic rd_end;
		pci_read_end <= 1'h1;
		repeat (40) @(posedge clk);
		apb(0, READ_STATE_OFFSET, 0);
		cmp({r[10:6], r[2:0]}, 8'h0);
	endtask : rd_end
	task automatic summarize;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// --------
	// Scenarios
	// --------
	task automatic t_writes;
		apb(0, CONTROL_OFFSET, 0);
		cmp(r, CONTROL_RESET);
		apb(0, 8'h40, 0);
		cmp(e, 1'h1);
		apb(1, CONTROL_OFFSET, 32'h1);
		for (int c = 1; c < 8; c++)
			wr(3'(c), 1, 1, (c inside {1, 2, 5, 7}) ? 4'he : 4'h8,
				9'h1 << (c < 3 ? c - 1 : c));
		wr(1, 0, 1, 0, 9'h1);
		wr(2, 0, 1, 8, 9'h2);
		wr(4, 0, 1, 0, 0);
		wr(6, 0, 1, 0, 0);
		wr(7, 0, 1, 8, 9'h80);
		apb(1, CONTROL_OFFSET, 32'h201);
		wr(4, 1, 1, 1, 0);
		wr(4, 1, 0, 1, 0);
		wr(4, 1, 0, 8, 9'h10);
		wr(3, 0, 1, 1, 0);
		wr(3, 0, 0, 1, 0);
		wr(3, 0, 0, 0, 9'h4);
		wr(3, 0, 1, 1, 0);
		$display("write errors done");
	endtask : t_writes
	task automatic t_reads;
		apb(1, LOCAL_LIMIT_OFFSET, 32'h13c);
		rd_cmd(CMD_MEM_READ_MULTIPLE, 32'h5500_0104, 4'h3);
		for (int k = 0; k < 10; k++)
		begin
			take(32'h104 + 32'(4 * k));
			if (k == 2)
				rd_cmd(CMD_MEM_READ, 32'h40, 0);
		end
		rd_end;
		rd_cmd(CMD_MEM_READ_LINE, 32'h106, 0);
		take(32'h104);
		rd_end;
		slow <= 1'h1;
		rd_cmd(CMD_MEM_READ, 32'hab00_0010, 4'h3);
		cmp({local_read_request, local_read_burst, local_read_be}, 6'h2c);
		cmp(local_read_addr, 32'h12);
		do @(posedge clk); while (pci_read_data_valid !== 1'h1);
		cmp(pci_disconnect_with_data, 1'h1);
		take(32'h12);
		rd_end;
		slow <= 1'h0;
		for (int i = 0; i < 2; i++)
		begin
			rd_cmd(i ? 4'ha : 4'h2, 32'h10, 0);
			cmp(local_read_request, 1'h0);
		end
		do_retry <= 1'h1;
		rd_cmd(CMD_MEM_READ, 32'h20, 0);
		do @(posedge clk); while (pci_retry !== 1'h1);
		cmp(pci_disconnect_without_data, 1'h1);
		do_retry <= 1'h0;
		rd_end;
		$display("reads done");
	endtask : t_reads
	// Main sequence and watchdog
	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		t_writes;
		t_reads;
		summarize;
	end
	initial
	begin
		repeat (30000) @(posedge clk);
		err_total++;
		summarize;
	end
endmodule : tb
